// ### logic_cell_gate_pkg.sv
// shared constants and carrier types for the gate-select block
package logic_cell_gate_pkg;

   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_GATE3_TERM_SELECT = 8'h00;
   localparam logic [7:0] OFS_CELL_OUTPUT_MIRROR = 8'h04;

   // register width and number of data inputs
   localparam int REG_WIDTH = 8;
   localparam int DATA_INPUTS = 4;

   // gate-select field positions
   localparam int SEL_IN4_TRUE = 7;
   localparam int SEL_IN4_INV = 6;
   localparam int SEL_IN3_TRUE = 5;
   localparam int SEL_IN3_INV = 4;
   localparam int SEL_IN2_TRUE = 3;
   localparam int SEL_IN2_INV = 2;
   localparam int SEL_IN1_TRUE = 1;
   localparam int SEL_IN1_INV = 0;

   // mirror register field positions
   localparam int MIRROR_CELL_ONE = 0;
   localparam int MIRROR_CELL_TWO = 1;

   // reset values
   localparam logic [1:0] MIRROR_RESET = 2'h0;
   localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

   // data inputs of the cell, first input in bit 0
   typedef struct packed {
      logic fourth;
      logic third;
      logic second;
      logic first;
   } data_inputs_t;

   // outputs of the two logic cells
   typedef struct packed {
      logic two;
      logic one;
   } cell_outputs_t;

   // apb slave answer state, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RESP = 2'b10
   } apb_state_t;

endpackage

// ### gate_term_combine.sv
// or of the enabled true and inverted data terms of one gate
module gate_term_combine #(
   parameter int N = 4
) (
   // term enables
   input wire logic [N-1:0] true_sel,
   input wire logic [N-1:0] inv_sel,
   // data inputs
   input wire logic [N-1:0] data,
   // combined gate value before polarity
   output logic gate
);

   logic [N-1:0] terms;

   // each input adds its true form, its inverted form, both or neither
   always_comb begin
      terms = (true_sel & data) | (inv_sel & ~data);
   end

   // no enabled term leaves the gate at zero
   assign gate = |terms;

endmodule

// ### logic_cell_gate_select.sv
// gate-select stage of one logic cell gate, with apb register access
// Notes on behaviour
// - select bit 7 gates fourth input true
// - select bit 6 gates fourth input inverted
// - select bit 5 gates third input true
// - select bit 4 gates third input inverted
// - select bit 3 gates second input true
// - select bit 2 gates second input inverted
// - select bit 1 gates first input true
// - select bit 0 gates first input inverted
// - select bits read/write, unknown at power-on, reset-kept
// - mirror bit 0 follows first cell output
// - mirror bit 1 follows second cell output
// - mirror bits 7..2 read zero, writes ignored
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
module logic_cell_gate_select (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // cell data inputs and cell outputs, same clock domain
   input wire logic_cell_gate_pkg::data_inputs_t data_in,
   input wire logic_cell_gate_pkg::cell_outputs_t cell_out,
   // gate value before polarity
   output logic gate_out
);

   logic_cell_gate_pkg::apb_state_t state_r;
   logic_cell_gate_pkg::apb_state_t state_nxt;
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic [7:0] select_r;
   logic [7:0] select_nxt;
   logic [1:0] mirror_r;
   logic [1:0] mirror_nxt;
   logic gate_r;
   logic gate_nxt;
   logic hit_select;
   logic hit_mirror;
   logic write_commit;
   logic [31:0] read_value;
   logic [3:0] true_sel;
   logic [3:0] inv_sel;
   logic [3:0] data_vec;
   logic gate_comb;
   logic sel_known_r;
   logic sel_known_nxt;

   // address decode; anything else is unmapped
   assign hit_select = (paddr == logic_cell_gate_pkg::OFS_GATE3_TERM_SELECT);
   assign hit_mirror = (paddr == logic_cell_gate_pkg::OFS_CELL_OUTPUT_MIRROR);

   // a write lands only at the edge where pready is seen high
   assign write_commit = psel && penable && pwrite && pready_r;

   // read mux, narrow data in the low bits, upper bits zero
   always_comb begin
      read_value = logic_cell_gate_pkg::PRDATA_RESET;
      if (hit_select) begin
         read_value[7:0] = select_r;
      end else if (hit_mirror) begin
         read_value[1:0] = mirror_r;
      end
   end

   // apb answer: one wait state, then pready for one cycle
   always_comb begin
      state_nxt = state_r;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      prdata_nxt = prdata_r;
      case (state_r)
         logic_cell_gate_pkg::ST_IDLE: begin
            if (psel && penable) begin
               state_nxt = logic_cell_gate_pkg::ST_RESP;
               pready_nxt = 1'b1;
               pslverr_nxt = !(hit_select || hit_mirror);
               prdata_nxt = pwrite ? logic_cell_gate_pkg::PRDATA_RESET : read_value;
            end
         end
         logic_cell_gate_pkg::ST_RESP: begin
            state_nxt = logic_cell_gate_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = logic_cell_gate_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= logic_cell_gate_pkg::ST_IDLE;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= logic_cell_gate_pkg::PRDATA_RESET;
      end else begin
         state_r <= state_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // select register; byte lane 0 carries it
   always_comb begin
      select_nxt = select_r;
      if (write_commit && hit_select && pstrb[0]) begin
         select_nxt = pwdata[7:0];
      end
   end

   // deliberately no reset term: the selection survives every reset
   always_ff @(posedge clk) begin
      select_r <= select_nxt;
   end

   // check helper: set by the first select write, unknown until then
   always_comb begin
      sel_known_nxt = sel_known_r | (write_commit && hit_select && pstrb[0]);
   end

   // no reset, like the select, so the hold check can span a reset
   always_ff @(posedge clk) begin
      sel_known_r <= sel_known_nxt;
   end

   // mirror of both cell outputs; writes to it are dropped
   always_comb begin
      mirror_nxt = logic_cell_gate_pkg::MIRROR_RESET;
      mirror_nxt[logic_cell_gate_pkg::MIRROR_CELL_ONE] = cell_out.one;
      mirror_nxt[logic_cell_gate_pkg::MIRROR_CELL_TWO] = cell_out.two;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mirror_r <= logic_cell_gate_pkg::MIRROR_RESET;
      end else begin
         mirror_r <= mirror_nxt;
      end
   end

   // unpack the selection into per-input true and inverted enables
   always_comb begin
      true_sel[3] = select_r[logic_cell_gate_pkg::SEL_IN4_TRUE];
      inv_sel[3] = select_r[logic_cell_gate_pkg::SEL_IN4_INV];
      true_sel[2] = select_r[logic_cell_gate_pkg::SEL_IN3_TRUE];
      inv_sel[2] = select_r[logic_cell_gate_pkg::SEL_IN3_INV];
      true_sel[1] = select_r[logic_cell_gate_pkg::SEL_IN2_TRUE];
      inv_sel[1] = select_r[logic_cell_gate_pkg::SEL_IN2_INV];
      true_sel[0] = select_r[logic_cell_gate_pkg::SEL_IN1_TRUE];
      inv_sel[0] = select_r[logic_cell_gate_pkg::SEL_IN1_INV];
      data_vec = data_in;
   end

   gate_term_combine #(
      .N(logic_cell_gate_pkg::DATA_INPUTS)
   ) u_gate (
      .true_sel(true_sel),
      .inv_sel(inv_sel),
      .data(data_vec),
      .gate(gate_comb)
   );

   // registered gate value; adds one cycle of latency
   always_comb begin
      gate_nxt = gate_comb;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gate_r <= 1'b0;
      end else begin
         gate_r <= gate_nxt;
      end
   end

   // outputs straight from flip-flops
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;
   assign gate_out = gate_r;

   // checks on the term gating, mirror and bus answer
   sequence s_access_wait;
      psel && penable && !pready_r;
   endsequence

   sequence s_ready_pulse;
      pready_r ##1 !pready_r;
   endsequence

   sequence s_sel_write;
      psel && penable && pwrite && pready_r && hit_select && pstrb[0];
   endsequence

   property p_term_drives(logic en, logic val);
      @(posedge clk) disable iff (!reset_n)
         (reset_n && en && val) |=> gate_r;
   endproperty

   AST_IN4_TRUE: assert property (p_term_drives(select_r[7], data_in.fourth))
      else $error("fourth input true term did not reach gate");
   AST_IN4_INV: assert property (p_term_drives(select_r[6], !data_in.fourth))
      else $error("fourth input inverted term did not reach gate");
   AST_IN3_TRUE: assert property (p_term_drives(select_r[5], data_in.third))
      else $error("third input true term did not reach gate");
   AST_IN3_INV: assert property (p_term_drives(select_r[4], !data_in.third))
      else $error("third input inverted term did not reach gate");
   AST_IN2_TRUE: assert property (p_term_drives(select_r[3], data_in.second))
      else $error("second input true term did not reach gate");
   AST_IN2_INV: assert property (p_term_drives(select_r[2], !data_in.second))
      else $error("second input inverted term did not reach gate");
   AST_IN1_TRUE: assert property (p_term_drives(select_r[1], data_in.first))
      else $error("first input true term did not reach gate");
   AST_IN1_INV: assert property (p_term_drives(select_r[0], !data_in.first))
      else $error("first input inverted term did not reach gate");

   AST_GATE_ZERO: assert property (
      @(posedge clk) disable iff (!reset_n)
         (((true_sel & data_vec) | (inv_sel & ~data_vec)) == 4'h0) |=> !gate_r)
      else $error("gate high with no enabled term true");

   AST_SEL_WRITE: assert property (
      @(posedge clk) disable iff (!reset_n)
         s_sel_write |=> (select_r == $past(pwdata[7:0])))
      else $error("select register did not take written byte");

   // no disable term: the selection must also ride through a reset
   AST_SEL_HOLD: assert property (
      @(posedge clk)
         (sel_known_r && !(write_commit && hit_select && pstrb[0])) |=> $stable(select_r))
      else $error("select register changed without a write");

   AST_MIRROR_ONE: assert property (
      @(posedge clk) disable iff (!reset_n)
         reset_n |=> (mirror_r[0] == $past(cell_out.one)))
      else $error("mirror bit 0 does not follow first cell");

   AST_MIRROR_TWO: assert property (
      @(posedge clk) disable iff (!reset_n)
         reset_n |=> (mirror_r[1] == $past(cell_out.two)))
      else $error("mirror bit 1 does not follow second cell");

   AST_MIRROR_UPPER: assert property (
      @(posedge clk) disable iff (!reset_n)
         (psel && penable && !pwrite && hit_mirror && !pready_r) |=>
            (prdata_r[31:2] == 30'h0 && prdata_r[1:0] == $past(mirror_r)))
      else $error("mirror read shows wrong bits");

   AST_APB_ANSWER: assert property (
      @(posedge clk) disable iff (!reset_n)
         s_access_wait |=> s_ready_pulse)
      else $error("apb answer not a single pulse after one wait");

   AST_UNMAPPED: assert property (
      @(posedge clk) disable iff (!reset_n)
         (s_access_wait and (!hit_select && !hit_mirror)) |=> (pslverr_r && pready_r))
      else $error("unmapped access not flagged");

   AST_SEL_STRB: assert property (
      @(posedge clk) disable iff (!reset_n)
         (sel_known_r && write_commit && hit_select && !pstrb[0]) |=> $stable(select_r))
      else $error("select register written with its byte lane off");

   AST_SEL_READ: assert property (
      @(posedge clk) disable iff (!reset_n)
         (sel_known_r && psel && penable && !pwrite && hit_select && !pready_r) |=>
            (prdata_r == {24'h000000, $past(select_r)}))
      else $error("select read shows wrong value");

   AST_MIRROR_NOERR: assert property (
      @(posedge clk) disable iff (!reset_n)
         (psel && penable && pwrite && hit_mirror && !pready_r) |=> (pready_r && !pslverr_r))
      else $error("write to mirror flagged as an error");

   AST_UNMAPPED_READ: assert property (
      @(posedge clk) disable iff (!reset_n)
         (psel && penable && !pwrite && !hit_select && !hit_mirror && !pready_r) |=>
            (prdata_r == 32'h0000_0000))
      else $error("unmapped read returns nonzero data");

   AST_WRITE_ZERO: assert property (
      @(posedge clk) disable iff (!reset_n)
         (psel && penable && pwrite && !pready_r) |=> (prdata_r == 32'h0000_0000))
      else $error("write answer carries nonzero read data");

   AST_BUS_QUIET: assert property (
      @(posedge clk) disable iff (!reset_n)
         !(psel && penable) |=> !pready_r)
      else $error("pready raised with no access phase");

   // reset sampled low must clear every registered output one edge later
   AST_RESET_OUTS: assert property (
      @(posedge clk)
         !reset_n |=> (!pready_r && !pslverr_r && !gate_r && prdata_r == 32'h0000_0000
            && mirror_r == 2'h0))
      else $error("outputs not cleared by reset");

endmodule

// ### test_logic_cell_gate_select.sv
// self-checking bench for the gate-select stage and its apb registers
module test_logic_cell_gate_select;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hF;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic gate_out;
   logic_cell_gate_pkg::data_inputs_t data_in = 4'h0;
   logic_cell_gate_pkg::cell_outputs_t cell_out = 2'h0;
   int fails = 0;
   int n_checks = 0;
   logic [31:0] rd;
   logic err;
   logic [7:0] s;
   logic [3:0] d;

   logic_cell_gate_select DUT (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .data_in(data_in), .cell_out(cell_out), .gate_out(gate_out)
   );

   // 100 MHz system clock
   always #5 clk = ~clk;

   // one comparison, counted
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // apb transfer; waits for pready without assuming a latency
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      // values read here are those sampled at this edge; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // or of every enabled true and inverted term
   function automatic logic exp_gate(input logic [7:0] sl, input logic [3:0] dv);
      exp_gate = 1'h0;
      for (int i = 0; i < 4; i++) begin
         if ((sl[2*i+1] && dv[i]) || (sl[2*i] && !dv[i])) exp_gate = 1'h1;
      end
   endfunction

   // write the select register and read it back
   task automatic set_sel(input logic [7:0] sl);
      apb(1'h1, logic_cell_gate_pkg::OFS_GATE3_TERM_SELECT, {24'h000000, sl});
      apb(1'h0, logic_cell_gate_pkg::OFS_GATE3_TERM_SELECT, 32'h0000_0000);
      chk("select readback", {24'h000000, sl}, rd);
   endtask

   // drive data inputs, let the registered gate settle, compare
   task automatic gate_chk(input logic [7:0] sl, input logic [3:0] dv);
      @(posedge clk);
      data_in <= dv;
      repeat (2) @(posedge clk);
      #1;
      chk("gate_out", 32'(exp_gate(sl, dv)), 32'(gate_out));
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // watchdog: the tests need well under 10000 cycles
   initial begin
      #200000;
      fails++;
      $display("ERROR watchdog expected finish seen hang");
      close_out();
   end

   initial begin
      void'($urandom(38));
      repeat (6) @(posedge clk);
      reset_n <= 1'h1;
      @(posedge clk);
      // each term alone over every input pattern
      for (int b = 0; b < 8; b++) begin
         set_sel(8'h01 << b);
         for (int v = 0; v < 16; v++) gate_chk(8'h01 << b, 4'(v));
      end
      $display("test single terms done");
      // nothing enabled must give zero whatever the inputs; everything enabled must give one
      set_sel(8'h00);
      for (int v = 0; v < 16; v++) gate_chk(8'h00, 4'(v));
      set_sel(8'hFF);
      gate_chk(8'hFF, 4'h5);
      $display("test no terms done");
      // random mixes of terms and inputs
      for (int k = 0; k < 50; k++) begin
         s = 8'($urandom);
         d = 4'($urandom);
         set_sel(s);
         gate_chk(s, d);
      end
      $display("test random terms done");
      // mirror follows both cell outputs; upper bits zero and unwritable
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         cell_out <= 2'(k ^ $urandom);
         repeat (2) @(posedge clk);
         apb(1'h1, logic_cell_gate_pkg::OFS_CELL_OUTPUT_MIRROR, 32'hFFFF_FFFF);
         apb(1'h0, logic_cell_gate_pkg::OFS_CELL_OUTPUT_MIRROR, 32'h0000_0000);
         chk("mirror", {30'h0, cell_out}, rd);
         chk("mirror error", 32'h0, 32'(err));
      end
      $display("test mirror done");
      // unmapped place refuses and leaves the select alone
      set_sel(8'h3C);
      apb(1'h1, 8'h08, 32'h0000_00FF);
      chk("unmapped write error", 32'h1, 32'(err));
      apb(1'h0, 8'h08, 32'h0000_0000);
      chk("unmapped read data", 32'h0, rd);
      // select write with its byte lane off must be dropped without error
      pstrb <= 4'hE;
      apb(1'h1, logic_cell_gate_pkg::OFS_GATE3_TERM_SELECT, 32'h0000_00FF);
      chk("masked write error", 32'h0, 32'(err));
      pstrb <= 4'hF;
      apb(1'h0, logic_cell_gate_pkg::OFS_GATE3_TERM_SELECT, 32'h0000_0000);
      chk("select after unmapped", 32'h0000_003C, rd);
      $display("test unmapped done");
      // ordinary reset keeps the select value
      set_sel(8'hA5);
      @(posedge clk);
      reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      @(posedge clk);
      apb(1'h0, logic_cell_gate_pkg::OFS_GATE3_TERM_SELECT, 32'h0000_0000);
      chk("select kept over reset", 32'h0000_00A5, rd);
      gate_chk(8'hA5, 4'h6);
      $display("test reset keep done");
      close_out();
   end
endmodule
